// ### sadc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Converter works only while enable is set
// - Ground negative input means single-ended mode
// - Single-ended results are unsigned eight bits
// - Single-ended half reference gives code 0x80
// - Differential results are two's complement
// - Differential negative full scale gives 0x80
// - Sensor and supply only as positive input
// - Eleven input selections through selection register
// - Two-bit gain field picks four gains
// - Gain resets to one half
// - Sensor routed positive, scaled by gain
// - Eight-bit successive approximation, 500 ksps
// - Conversion clock is clock over divider+1
// - Start field picks one of five triggers
// - Conversion end sets done flag; abort by disable does not
// - Low-power mode tracks three conversion ticks
// ============================================================
// Register front end and control of the 8-bit converter.
module sadc_ctrl (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave.
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Conversion triggers.
  input  wire logic        tmr0_ovf,
  input  wire logic        tmr1_ovf,
  input  wire logic        tmr2_ovf,
  input  wire logic        external_start_strobe,
  // Analog comparator result, asynchronous.
  input  wire logic        comp_in,
  // Analog steering.
  output logic             analog_en,
  output logic      [3:0]  pos_sel,
  output logic      [3:0]  neg_sel,
  output logic             diff_mode,
  output logic      [1:0]  amp_gain,
  output logic      [7:0]  dac_code,
  output logic             track
);

  sadc_pkg::sadc_regs_s r;
  sadc_pkg::sadc_regs_s next_r;

  logic       sar_busy;
  logic       sar_done;
  logic [7:0] sar_result;
  logic       start;
  logic       do_write;
  logic       stb_rise;

  // ============================================================
  // Trigger selection.

  // A strobe rise is seen only after the two-stage synchroniser.
  assign stb_rise = r.stb_sync && !r.stb_prev;
  assign do_write = write && !r.waitrequest;

  always_comb
  begin
    case (r.src)
      sadc_pkg::SRC_SOFT:   start = r.sw_start;
      sadc_pkg::SRC_TMR0:   start = tmr0_ovf;
      sadc_pkg::SRC_TMR2:   start = tmr2_ovf;
      sadc_pkg::SRC_TMR1:   start = tmr1_ovf;
      sadc_pkg::SRC_STROBE: start = stb_rise;
      default:              start = 1'b0;
    endcase
  end

  // ============================================================
  // Approximation engine.
  sadc_sar u_sar (
    .clk      (clk),
    .rst      (rst),
    .enable   (r.enable),
    .start    (start),
    .tick     (r.tick),
    .lp_track (r.lpt),
    .comp_in  (comp_in),
    .busy     (sar_busy),
    .done     (sar_done),
    .result   (sar_result),
    .dac_code (dac_code),
    .track    (track)
  );

  // ============================================================
  // Next-state logic of the register file and bus slave.
  always_comb
  begin
    next_r          = r;
    next_r.sw_start = 1'b0;
    next_r.stb_meta = external_start_strobe;
    next_r.stb_sync = r.stb_meta;
    next_r.stb_prev = r.stb_sync;

    if (r.div_cnt >= r.div)
    begin
      next_r.div_cnt = 5'h00;
      next_r.tick    = 1'b1;
    end
    else
    begin
      next_r.div_cnt = r.div_cnt + 5'h01;
      next_r.tick    = 1'b0;
    end

    next_r.diff = (r.neg != sadc_pkg::NEG_GND);

    // Bus handshake: answer one cycle after the request appears.
    if ((read || write) && r.waitrequest)
    begin
      next_r.waitrequest = 1'b0;
      next_r.readdata    = 32'h0000_0000;
      if (read)
      begin
        case (address)
          sadc_pkg::REG_CTRL:
          begin
            next_r.readdata[sadc_pkg::CTRL_EN_BIT]   = r.enable;
            next_r.readdata[sadc_pkg::CTRL_BUSY_BIT] = sar_busy;
            next_r.readdata[sadc_pkg::CTRL_DONE_BIT] = r.done;
            next_r.readdata[sadc_pkg::CTRL_SRC_LSB +: 3] = r.src;
            next_r.readdata[sadc_pkg::CTRL_LPT_BIT]  = r.lpt;
          end
          sadc_pkg::REG_SELECT:
          begin
            next_r.readdata[sadc_pkg::SEL_POS_LSB +: 4] = r.pos;
            next_r.readdata[sadc_pkg::SEL_NEG_LSB +: 4] = r.neg;
          end
          sadc_pkg::REG_CONFIG:
          begin
            next_r.readdata[sadc_pkg::CFG_GAIN_LSB +: 2] = r.gain;
            next_r.readdata[sadc_pkg::CFG_DIV_LSB +: 5]  = r.div;
          end
          sadc_pkg::REG_DATA:
          begin
            next_r.readdata[7:0] = r.data;
          end
          sadc_pkg::REG_STATUS:
          begin
            next_r.readdata[sadc_pkg::STAT_TRACK_BIT] = track;
            next_r.readdata[sadc_pkg::STAT_DIFF_BIT]  = r.diff;
            next_r.readdata[sadc_pkg::STAT_BUSY_BIT]  = sar_busy;
          end
          default:
          begin
            next_r.readdata = 32'h0000_0000;
          end
        endcase
      end
    end
    else
    begin
      next_r.waitrequest = 1'b1;
    end

    // Writes take effect on the edge that completes the transfer.
    if (do_write)
    begin
      case (address)
        sadc_pkg::REG_CTRL:
        begin
          next_r.enable = writedata[sadc_pkg::CTRL_EN_BIT];
          next_r.src    = writedata[sadc_pkg::CTRL_SRC_LSB +: 3];
          next_r.lpt    = writedata[sadc_pkg::CTRL_LPT_BIT];
          if (!writedata[sadc_pkg::CTRL_DONE_BIT])
          begin
            next_r.done = 1'b0;
          end
          next_r.sw_start = writedata[sadc_pkg::CTRL_BUSY_BIT];
        end
        sadc_pkg::REG_SELECT:
        begin
          if (writedata[sadc_pkg::SEL_POS_LSB +: 4] <= sadc_pkg::POS_SUPPLY)
          begin
            next_r.pos = writedata[sadc_pkg::SEL_POS_LSB +: 4];
          end
          if (writedata[sadc_pkg::SEL_NEG_LSB +: 4] <= sadc_pkg::NEG_GND)
          begin
            next_r.neg = writedata[sadc_pkg::SEL_NEG_LSB +: 4];
          end
        end
        sadc_pkg::REG_CONFIG:
        begin
          next_r.gain = writedata[sadc_pkg::CFG_GAIN_LSB +: 2];
          next_r.div  = writedata[sadc_pkg::CFG_DIV_LSB +: 5];
        end
        default:
        begin
          next_r.src = r.src;
        end
      endcase
    end

    if (sar_done)
    begin
      next_r.done = 1'b1;
      if (r.diff)
      begin
        next_r.data = sar_result ^ sadc_pkg::SIGN_FLIP;
      end
      else
      begin
        next_r.data = sar_result;
      end
    end
  end

  // ============================================================
  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r             <= '0;
      r.gain        <= sadc_pkg::GAIN_HALF;
      r.neg         <= sadc_pkg::NEG_GND;
      r.data        <= sadc_pkg::RST_BYTE;
      r.src         <= sadc_pkg::SRC_SOFT;
      r.waitrequest <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ============================================================
  // Outputs straight from the state register.
  assign readdata    = r.readdata;
  assign waitrequest = r.waitrequest;
  assign analog_en   = r.enable;
  assign pos_sel     = r.pos;
  assign neg_sel     = r.neg;
  assign diff_mode   = r.diff;
  assign amp_gain    = r.gain;

endmodule // sadc_ctrl
`default_nettype wire

// ### sadc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker of the converter control block.
module sadc_monitor (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Avalon-MM slave.
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  // Analog steering.
  input wire logic        analog_en,
  input wire logic [3:0]  pos_sel,
  input wire logic [3:0]  neg_sel,
  input wire logic        diff_mode,
  input wire logic [1:0]  amp_gain,
  input wire logic [7:0]  dac_code
);
  logic wr_ctl;
  logic wr_sel;
  logic wr_cfg;

  // Completed writes to the control, selection and configuration registers.
  assign wr_ctl = write && !waitrequest && (address == sadc_pkg::REG_CTRL);
  assign wr_sel = write && !waitrequest && (address == sadc_pkg::REG_SELECT);
  assign wr_cfg = write && !waitrequest && (address == sadc_pkg::REG_CONFIG);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest stayed low");
  a_req_answered: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered in one cycle");
  a_enable_by_write: assert property (
    !$past(rst) && $changed(analog_en) |-> $past(wr_ctl) || $past(wr_ctl, 2))
    else $error("enable changed without a control write");
  a_off_code_still: assert property (!analog_en [*3] |=> $stable(dac_code))
    else $error("trial code moved while disabled");
  a_mode_from_neg: assert property (
    !$past(rst) |-> diff_mode == ($past(neg_sel) != sadc_pkg::NEG_GND))
    else $error("mode does not follow negative input");
  a_sel_legal: assert property (
    pos_sel <= sadc_pkg::POS_SUPPLY && neg_sel <= sadc_pkg::NEG_GND)
    else $error("illegal input selection");
  a_sel_by_write: assert property (
    !$past(rst) && $changed({pos_sel, neg_sel}) |-> $past(wr_sel) || $past(wr_sel, 2))
    else $error("selection changed without a write");
  a_gain_by_write: assert property (
    !$past(rst) && $changed(amp_gain) |-> $past(wr_cfg) || $past(wr_cfg, 2))
    else $error("gain changed without a write");
  a_gain_reset: assert property ($fell(rst) |-> amp_gain == sadc_pkg::GAIN_HALF)
    else $error("gain not one half after reset");
endmodule // sadc_monitor

bind sadc_ctrl sadc_monitor u_mon (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .waitrequest(waitrequest), .analog_en(analog_en), .pos_sel(pos_sel),
  .neg_sel(neg_sel), .diff_mode(diff_mode), .amp_gain(amp_gain), .dac_code(dac_code)
);
`default_nettype wire

// ### sadc_pkg.sv
// ============================================================
// Shared constants and state types for the converter control block.
package sadc_pkg;

  // ============================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_SELECT = 5'h04;
  localparam logic [4:0] REG_CONFIG = 5'h08;
  localparam logic [4:0] REG_DATA   = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // ============================================================
  // Field positions in the control register.
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_BUSY_BIT = 1;
  localparam int CTRL_DONE_BIT = 2;
  localparam int CTRL_SRC_LSB  = 3;
  localparam int CTRL_LPT_BIT  = 6;

  // Field positions in the selection and configuration registers.
  localparam int SEL_POS_LSB = 0;
  localparam int SEL_NEG_LSB = 4;
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_DIV_LSB  = 3;

  // Field positions in the status register.
  localparam int STAT_TRACK_BIT = 0;
  localparam int STAT_DIFF_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 2;

  // ============================================================
  // Start sources of a conversion.
  localparam logic [2:0] SRC_SOFT  = 3'h0;
  localparam logic [2:0] SRC_TMR0  = 3'h1;
  localparam logic [2:0] SRC_TMR2  = 3'h2;
  localparam logic [2:0] SRC_TMR1  = 3'h3;
  localparam logic [2:0] SRC_STROBE = 3'h4;

  // Input selection codes: pins 0 to 7, then sensor and supply at 8 and 9 on the positive side, ground at 8 on the negative side.
  localparam logic [3:0] SEL_PIN_MAX = 4'h7;
  localparam logic [3:0] POS_TEMP    = 4'h8;
  localparam logic [3:0] POS_SUPPLY  = 4'h9;
  localparam logic [3:0] NEG_GND     = 4'h8;

  // Gain codes: 0.5, 1, 2 and 4.
  localparam logic [1:0] GAIN_HALF = 2'h0;
  localparam logic [1:0] GAIN_ONE  = 2'h1;
  localparam logic [1:0] GAIN_TWO  = 2'h2;
  localparam logic [1:0] GAIN_FOUR = 2'h3;

  // ============================================================
  // Reset values and timing counts.
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] SAR_MSB_CODE = 8'h80;
  localparam logic [7:0] SIGN_FLIP    = 8'h80;
  localparam logic [2:0] MSB_INDEX    = 3'h7;
  localparam logic [1:0] TRACK_TICKS  = 2'h3;
  localparam logic [1:0] SETTLE_CYC   = 2'h3;

  // ============================================================
  // One-hot states of the approximation engine.
  typedef enum logic [2:0] {
    SADC_IDLE  = 3'b001,
    SADC_TRACK = 3'b010,
    SADC_CONV  = 3'b100
  } sadc_state_e;

  // Whole state of the approximation engine.
  typedef struct packed {
    sadc_state_e state;
    logic [1:0]  trk_cnt;
    logic [1:0]  settle;
    logic [2:0]  bit_idx;
    logic [7:0]  code;
    logic [7:0]  result;
    logic        busy;
    logic        done;
    logic        track;
    logic        cmp_meta;
    logic        cmp_sync;
  } sadc_sar_s;

  // Whole state of the control block.
  typedef struct packed {
    logic        enable;
    logic [2:0]  src;
    logic        lpt;
    logic        done;
    logic [3:0]  pos;
    logic [3:0]  neg;
    logic        diff;
    logic [1:0]  gain;
    logic [4:0]  div;
    logic [4:0]  div_cnt;
    logic        tick;
    logic [7:0]  data;
    logic        stb_meta;
    logic        stb_sync;
    logic        stb_prev;
    logic        sw_start;
    logic [31:0] readdata;
    logic        waitrequest;
  } sadc_regs_s;

endpackage

// ### sadc_sar.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Successive-approximation engine paced by the conversion clock tick.
module sadc_sar (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control from the register side.
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic       lp_track,
  // Comparator from the analog side, asynchronous.
  input  wire logic       comp_in,
  // Results and analog steering.
  output logic            busy,
  output logic            done,
  output logic [7:0]      result,
  output logic [7:0]      dac_code,
  output logic            track
);

  sadc_pkg::sadc_sar_s r;
  sadc_pkg::sadc_sar_s next_r;

  // Next-state logic of the engine.
  always_comb
  begin
    next_r          = r;
    next_r.done     = 1'b0;
    next_r.cmp_meta = comp_in;
    next_r.cmp_sync = r.cmp_meta;
    if (r.settle != sadc_pkg::SETTLE_CYC)
    begin
      next_r.settle = r.settle + 2'h1;
    end
    case (r.state)
      sadc_pkg::SADC_IDLE:
      begin
        next_r.track = enable && !lp_track;
        if (start && enable)
        begin
          next_r.busy = 1'b1;
          if (lp_track)
          begin
            next_r.state   = sadc_pkg::SADC_TRACK;
            next_r.trk_cnt = 2'h0;
            next_r.track   = 1'b1;
          end
          else
          begin
            next_r.state   = sadc_pkg::SADC_CONV;
            next_r.code    = sadc_pkg::SAR_MSB_CODE;
            next_r.bit_idx = sadc_pkg::MSB_INDEX;
            next_r.settle  = 2'h0;
            next_r.track   = 1'b0;
          end
        end
      end
      sadc_pkg::SADC_TRACK:
      begin
        if (tick)
        begin
          next_r.trk_cnt = r.trk_cnt + 2'h1;
          if (r.trk_cnt == sadc_pkg::TRACK_TICKS - 2'h1)
          begin
            next_r.state   = sadc_pkg::SADC_CONV;
            next_r.code    = sadc_pkg::SAR_MSB_CODE;
            next_r.bit_idx = sadc_pkg::MSB_INDEX;
            next_r.settle  = 2'h0;
            next_r.track   = 1'b0;
          end
        end
      end
      sadc_pkg::SADC_CONV:
      begin
        if (tick && (r.settle == sadc_pkg::SETTLE_CYC))
        begin
          next_r.code[r.bit_idx] = r.cmp_sync;
          next_r.settle          = 2'h0;
          if (r.bit_idx == 3'h0)
          begin
            next_r.state  = sadc_pkg::SADC_IDLE;
            next_r.busy   = 1'b0;
            next_r.done   = 1'b1;
            next_r.result = {r.code[7:1], r.cmp_sync};
            next_r.track  = !lp_track;
          end
          else
          begin
            next_r.bit_idx                = r.bit_idx - 3'h1;
            next_r.code[r.bit_idx - 3'h1] = 1'b1;
          end
        end
      end
      default:
      begin
        next_r.state = sadc_pkg::SADC_IDLE;
        next_r.busy  = 1'b0;
      end
    endcase
    if (!enable)
    begin
      next_r.state = sadc_pkg::SADC_IDLE;
      next_r.busy  = 1'b0;
      next_r.done  = 1'b0;
      next_r.track = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r       <= '0;
      r.state <= sadc_pkg::SADC_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign busy     = r.busy;
  assign done     = r.done;
  assign result   = r.result;
  assign dac_code = r.code;
  assign track    = r.track;

endmodule // sadc_sar
`default_nettype wire

// ### sadc_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Compares a seen value with the expected one and counts both outcomes.
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
// ============================================================
// Self-checking bench of the converter control block.
module testbench;
  logic        clk, rst, read, write, tmr0_ovf, tmr1_ovf, tmr2_ovf, external_start_strobe;
  logic        comp_in, waitrequest, analog_en, diff_mode, track;
  logic [4:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  pos_sel, neg_sel;
  logic [1:0]  amp_gain;
  logic [7:0]  dac_code, vin;
  int          mismatches = 0, num_checks = 0, cyc = 0;

  // Clock and cycle count.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  // Comparator: input level at or above the trial code.
  assign comp_in = (vin >= dac_code);

  sadc_ctrl uut (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .tmr2_ovf(tmr2_ovf),
    .external_start_strobe(external_start_strobe), .comp_in(comp_in),
    .analog_en(analog_en), .pos_sel(pos_sel), .neg_sel(neg_sel), .diff_mode(diff_mode),
    .amp_gain(amp_gain), .dac_code(dac_code), .track(track)
  );

  // ============================================================
  // Bus and report tasks.
  task automatic finish_test();
    if (mismatches == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_ack();
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        return;
    end
    mismatches++;
    $display("[ERR] waitrequest expected 0 seen 1");
    finish_test();
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_read(input logic [4:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    wait_ack();
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(logic en, logic go, logic [2:0] src, logic lp);
    ctl = 32'h0;
    ctl[sadc_pkg::CTRL_EN_BIT] = en;
    ctl[sadc_pkg::CTRL_BUSY_BIT] = go;
    ctl[sadc_pkg::CTRL_SRC_LSB +: 3] = src;
    ctl[sadc_pkg::CTRL_LPT_BIT] = lp;
  endfunction

  task automatic wait_done();
    logic [31:0] d;
    for (int n = 0; n < 300; n++)
    begin
      bus_read(sadc_pkg::REG_CTRL, d);
      if (d[sadc_pkg::CTRL_DONE_BIT] === 1'b1)
        return;
    end
    mismatches++;
    $display("[ERR] done expected 1 seen 0");
    finish_test();
  endtask

  // ============================================================
  // Scenarios.
  task automatic t_reset();
    logic [31:0] d;
    bus_read(sadc_pkg::REG_CTRL, d);
    `CHK("ctrl", 32'h0, d)
    bus_read(sadc_pkg::REG_SELECT, d);
    `CHK("select", 32'h80, d)
    bus_read(sadc_pkg::REG_CONFIG, d);
    `CHK("config", 32'h0, d)
    bus_read(5'h14, d);
    `CHK("unmapped", 32'h0, d)
    `CHK("gain", sadc_pkg::GAIN_HALF, amp_gain)
    `CHK("diff", 1'b0, diff_mode)
  endtask

  task automatic t_select();
    logic [31:0] d;
    bus_write(sadc_pkg::REG_SELECT, 32'h88);
    repeat (2) @(posedge clk);
    `CHK("pos_sel", sadc_pkg::POS_TEMP, pos_sel)
    `CHK("diff", 1'b0, diff_mode)
    bus_write(sadc_pkg::REG_SELECT, 32'h23);
    bus_write(sadc_pkg::REG_SELECT, 32'h9A);
    bus_read(sadc_pkg::REG_SELECT, d);
    `CHK("select", 32'h23, d)
    bus_read(sadc_pkg::REG_STATUS, d);
    `CHK("status_diff", 1'b1, d[sadc_pkg::STAT_DIFF_BIT])
    bus_write(sadc_pkg::REG_SELECT, 32'h09);
    repeat (2) @(posedge clk);
    `CHK("sel", {4'h0, sadc_pkg::POS_SUPPLY}, {neg_sel, pos_sel})
  endtask

  task automatic t_gain();
    logic [31:0] d;
    for (int g = 0; g < 4; g++)
    begin
      bus_write(sadc_pkg::REG_CONFIG, 32'(g));
      bus_read(sadc_pkg::REG_CONFIG, d);
      `CHK("amp_gain", 2'(g), amp_gain)
      `CHK("config", 32'(g), d)
    end
  endtask

  task automatic t_rerst();
    logic [31:0] d;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("gain_rst", sadc_pkg::GAIN_HALF, amp_gain)
    bus_read(sadc_pkg::REG_CONFIG, d);
    `CHK("config_rst", 32'h0, d)
  endtask

  task automatic t_conv(input logic [31:0] sel, input logic [4:0] div, input logic lp,
                        input logic [7:0] v, input logic [7:0] exp);
    logic [31:0] d;
    int          t0;
    vin <= v;
    bus_write(sadc_pkg::REG_SELECT, sel);
    bus_write(sadc_pkg::REG_CONFIG, 32'(div) << sadc_pkg::CFG_DIV_LSB);
    bus_write(sadc_pkg::REG_CTRL, ctl(1'b1, 1'b1, sadc_pkg::SRC_SOFT, lp));
    t0 = cyc;
    wait_done();
    `CHK("conv_time", 1'b1, (cyc - t0) >= (lp ? 10 : 8) * (int'(div) + 1))
    `CHK("track_idle", ~lp, track)
    bus_read(sadc_pkg::REG_DATA, d);
    `CHK("data", {24'h0, exp}, d)
    bus_write(sadc_pkg::REG_CTRL, ctl(1'b1, 1'b0, sadc_pkg::SRC_SOFT, lp));
    bus_read(sadc_pkg::REG_CTRL, d);
    `CHK("done_clear", 1'b0, d[sadc_pkg::CTRL_DONE_BIT])
    bus_read(sadc_pkg::REG_DATA, d);
    `CHK("data_hold", {24'h0, exp}, d)
  endtask

  task automatic t_triggers();
    logic [31:0] d;
    vin <= 8'h40;
    bus_write(sadc_pkg::REG_SELECT, 32'h81);
    bus_write(sadc_pkg::REG_CONFIG, 32'h18);
    for (int s = 1; s <= 4; s++)
    begin
      bus_write(sadc_pkg::REG_CTRL, ctl(1'b1, 1'b0, 3'(s), 1'b0));
      tmr1_ovf <= (s == 1);
      tmr0_ovf <= (s != 1);
      @(posedge clk);
      tmr0_ovf <= 1'b0;
      tmr1_ovf <= 1'b0;
      repeat (8) @(posedge clk);
      bus_read(sadc_pkg::REG_STATUS, d);
      `CHK("wrong_source", 1'b0, d[sadc_pkg::STAT_BUSY_BIT])
      tmr0_ovf <= (s == 1);
      tmr2_ovf <= (s == 2);
      tmr1_ovf <= (s == 3);
      external_start_strobe <= (s == 4);
      @(posedge clk);
      {tmr0_ovf, tmr1_ovf, tmr2_ovf} <= 3'h0;
      repeat (3) @(posedge clk);
      external_start_strobe <= 1'b0;
      wait_done();
      bus_read(sadc_pkg::REG_DATA, d);
      `CHK("trig_data", 32'h40, d)
    end
  endtask

  task automatic t_abort();
    logic [31:0] d;
    vin <= 8'hFF;
    bus_write(sadc_pkg::REG_CONFIG, 32'hF8);
    bus_write(sadc_pkg::REG_CTRL, ctl(1'b1, 1'b1, sadc_pkg::SRC_SOFT, 1'b0));
    bus_write(sadc_pkg::REG_CTRL, ctl(1'b0, 1'b1, sadc_pkg::SRC_SOFT, 1'b0));
    repeat (400) @(posedge clk);
    bus_read(sadc_pkg::REG_CTRL, d);
    `CHK("ctrl_off", 32'h0, d)
    `CHK("analog_en", 1'b0, analog_en)
    bus_read(sadc_pkg::REG_DATA, d);
    `CHK("data_kept", 32'h40, d)
  endtask

  // Main sequence.
  initial
  begin
    {rst, read, write, tmr0_ovf, tmr1_ovf, tmr2_ovf, external_start_strobe} = 7'h40;
    address = 5'h00;
    writedata = 32'h0;
    vin = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_select();
    t_gain();
    t_rerst();
    t_conv(32'h81, 5'h00, 1'b0, 8'h00, 8'h00);
    t_conv(32'h81, 5'h00, 1'b0, 8'h80, 8'h80);
    // sensor against ground at a known level.
    t_conv(32'h88, 5'h00, 1'b0, 8'hFF, 8'hFF);
    t_conv(32'h21, 5'h00, 1'b0, 8'h00, 8'h80);
    t_conv(32'h21, 5'h00, 1'b0, 8'h40, 8'hC0);
    t_conv(32'h21, 5'h02, 1'b0, 8'h80, 8'h00);
    t_conv(32'h21, 5'h00, 1'b1, 8'hFF, 8'h7F);
    t_conv(32'h81, 5'h1F, 1'b1, 8'h40, 8'h40);
    t_triggers();
    t_abort();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
